// File: hdl/nv_access_pkg.sv
package nv_access_pkg;

  // ----------------------------------------------------------------
  // Command space locations
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_SUBCLASS  = 7'h3e; // Flash subclass select
  localparam logic [6:0] ADDR_BLOCK     = 7'h3f; // Flash block select
  localparam logic [6:0] ADDR_WIN_BASE  = 7'h40; // First window byte
  localparam logic [6:0] ADDR_WIN_LAST  = 7'h5f; // Last window byte
  localparam logic [6:0] ADDR_CHECKSUM  = 7'h60; // Block checksum
  localparam logic [6:0] ADDR_MODE      = 7'h61; // Block access mode select

  // ----------------------------------------------------------------
  // Sizes and codes
  // ----------------------------------------------------------------
  localparam int         WIN_BYTES      = 32;    // Window and info block
  localparam logic [4:0] WIN_LAST_IDX   = 5'h1f; // Last window index
  localparam logic [7:0] MODE_GENERAL   = 8'h00; // Subclass addressing
  localparam logic [7:0] MODE_RESET     = 8'h00; // Mode after reset
  localparam logic [7:0] INFO_BLOCK_A   = 8'h01; // Info block selector
  localparam logic [7:0] INFO_BLOCK_B   = 8'h02; // Info block selector
  localparam logic [7:0] BYTE_RESET     = 8'h00; // Byte fields at reset
  localparam logic [7:0] INFO_RESET     = 8'h00; // Erased info byte

  // ----------------------------------------------------------------
  // Control port codes and stored key defaults (arbitrary values)
  // ----------------------------------------------------------------
  localparam logic [15:0] CMD_SEAL         = 16'h0020; // Seal subcommand
  localparam logic [15:0] UNSEAL_KEY1_RST  = 16'h4c2b; // Arbitrary
  localparam logic [15:0] UNSEAL_KEY0_RST  = 16'h9e17; // Arbitrary
  localparam logic [15:0] FULL_KEY1_RST    = 16'hffff; // Arbitrary
  localparam logic [15:0] FULL_KEY0_RST    = 16'hffff; // Arbitrary

  // Key slot selectors for the key update and read ports
  localparam logic [1:0] KEY_UNSEAL0 = 2'h0;
  localparam logic [1:0] KEY_UNSEAL1 = 2'h1;
  localparam logic [1:0] KEY_FULL0   = 2'h2;
  localparam logic [1:0] KEY_FULL1   = 2'h3;

  // Security levels
  typedef enum logic [1:0] {
    SEC_SEALED,
    SEC_UNSEALED,
    SEC_FULL
  } sec_level_type;

  // Flash transfer engine states
  typedef enum logic [1:0] {
    XFER_IDLE,
    XFER_LOAD,
    XFER_STORE
  } xfer_state_type;

endpackage : nv_access_pkg

// File: hdl/block_checksum_calc.sv
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Checksum of the window: ones' complement of the low sum byte
// ------------------------------------------------------------------
module block_checksum_calc
  import nv_access_pkg::*;
(
  input  wire logic [255:0] win_flat_i,  // Window, byte 0 in bits 7:0
  output logic      [7:0]   expected_o   // Checksum the host must send
);

  // Only the low byte of the sum matters, so carries are dropped
  always_comb begin
    logic [7:0] sum_v;
    sum_v = 8'h00;
    for (int i = 0; i < WIN_BYTES; i++) begin
      sum_v = sum_v + win_flat_i[i*8 +: 8];
    end
    expected_o = ~sum_v;  // Equals 255 minus the low byte
  end

endmodule : block_checksum_calc

// File: hdl/secure_flash_block_access.sv
`timescale 1ns/1ps

module secure_flash_block_access
  import nv_access_pkg::*;
(
  input  wire logic        sys_clk_i,         // System clock
  input  wire logic        arst_n_i,          // Async reset, active low
  // Host command space
  input  wire logic        cmd_wr_i,          // Write strobe
  input  wire logic        cmd_rd_i,          // Read strobe
  input  wire logic [6:0]  cmd_addr_i,        // Command location
  input  wire logic [7:0]  cmd_wdata_i,       // Write byte
  output logic      [7:0]  cmd_rdata_o,       // Read byte, next cycle
  output logic             busy_o,            // Flash transfer running
  // Control command port
  input  wire logic        ctrl_wr_i,         // Control word write
  input  wire logic [15:0] ctrl_wdata_i,      // Control word
  output logic             sealed_flag_o,     // Sealed state flag
  output logic             full_access_state_flag_o, // Low at full
  // Key maintenance port
  input  wire logic        key_wr_i,          // Key update strobe
  input  wire logic        key_rd_i,          // Key read strobe
  input  wire logic [1:0]  key_sel_i,         // Key slot
  input  wire logic [15:0] key_wdata_i,       // New key value
  output logic      [15:0] key_rdata_o,       // Key read, next cycle
  // General data flash
  output logic             flash_rd_o,        // Read one byte
  output logic             flash_wr_o,        // Program one byte
  output logic      [7:0]  flash_subclass_o,  // Subclass of transfer
  output logic      [7:0]  flash_block_o,     // 32-byte block number
  output logic      [4:0]  flash_idx_o,       // Byte within block
  output logic      [7:0]  flash_wdata_o,     // Byte to program
  input  wire logic [7:0]  flash_rdata_i      // Byte read, same cycle
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sec_level_type  level_reg;                 // Security level
  xfer_state_type xfer_reg;                  // Flash transfer state
  logic [4:0]     xfer_idx_reg;              // Transfer byte counter
  logic [7:0]     subclass_reg;              // Flash subclass select
  logic [7:0]     block_reg;                 // Flash block select
  logic [7:0]     mode_reg;                  // Block access mode select
  logic [7:0]     checksum_reg;              // Last checksum written
  logic [7:0]     win_reg  [WIN_BYTES];      // Block window
  logic [7:0]     info_reg [WIN_BYTES];      // Manufacturer info block
  logic           info_sel_reg;              // Window holds info block
  logic [15:0]    unseal_key0_reg;           // Stored unseal key 0
  logic [15:0]    unseal_key1_reg;           // Stored unseal key 1
  logic [15:0]    full_key0_reg;             // Stored full-access key 0
  logic [15:0]    full_key1_reg;             // Stored full-access key 1
  logic           key1_seen_reg;             // First key of a pair seen

  logic [255:0]   win_flat;                  // Window for the checksum
  logic [7:0]     expected_sum;              // Checksum that matches
  logic           sealed;                    // Level is sealed
  logic           general_mode;              // Subclass addressing on
  logic           idle;                      // No transfer running
  logic           wr_block;                  // Block select written
  logic           wr_win;                    // Window byte written
  logic           wr_sum;                    // Checksum written
  logic           sum_ok;                    // Checksum matches window
  logic [4:0]     win_idx;                   // Window index of address
  logic [15:0]    key1_swapped;              // Expected first entry
  logic [15:0]    key0_swapped;              // Expected second entry

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign sealed       = (level_reg == SEC_SEALED);
  assign general_mode = !sealed && (mode_reg == MODE_GENERAL);
  assign idle         = (xfer_reg == XFER_IDLE);
  // Host writes during a transfer are dropped; busy_o tells the host
  assign wr_block = cmd_wr_i && idle && (cmd_addr_i == ADDR_BLOCK);
  assign wr_win   = cmd_wr_i && idle && !sealed &&
                    (cmd_addr_i >= ADDR_WIN_BASE) &&
                    (cmd_addr_i <= ADDR_WIN_LAST);
  assign wr_sum   = cmd_wr_i && idle && (cmd_addr_i == ADDR_CHECKSUM);
  assign win_idx  = cmd_addr_i[4:0];  // 0x40 base drops out
  assign sum_ok   = (cmd_wdata_i == expected_sum);
  assign busy_o   = !idle;

  // Flatten the window for the checksum unit
  generate
    for (genvar g = 0; g < WIN_BYTES; g++) begin : g_flat
      assign win_flat[g*8 +: 8] = win_reg[g];
    end
  endgenerate

  block_checksum_calc u_checksum (
    .win_flat_i (win_flat),
    .expected_o (expected_sum)
  );

  // ----------------------------------------------------------------
  // Selection registers
  // ----------------------------------------------------------------
  // Subclass and mode are not reachable while sealed
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      subclass_reg <= BYTE_RESET;
      mode_reg     <= MODE_RESET;
      block_reg    <= BYTE_RESET;
      checksum_reg <= BYTE_RESET;
    end else begin
      if (cmd_wr_i && idle && !sealed) begin
        if (cmd_addr_i == ADDR_SUBCLASS) begin
          subclass_reg <= cmd_wdata_i;
        end
        if (cmd_addr_i == ADDR_MODE) begin
          mode_reg <= cmd_wdata_i;
        end
      end
      if (wr_block) begin
        block_reg <= cmd_wdata_i;
      end
      if (wr_sum) begin
        checksum_reg <= cmd_wdata_i;  // Kept for readback either way
      end
    end
  end

  // ----------------------------------------------------------------
  // Flash transfer engine: one byte per cycle, 32 cycles per block
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      xfer_reg     <= XFER_IDLE;
      xfer_idx_reg <= 5'h00;
    end else begin
      case (xfer_reg)
        XFER_IDLE: begin
          xfer_idx_reg <= 5'h00;
          if (wr_block && general_mode) begin
            xfer_reg <= XFER_LOAD;
          end else if (wr_sum && general_mode && sum_ok) begin
            xfer_reg <= XFER_STORE;
          end
        end
        XFER_LOAD, XFER_STORE: begin
          xfer_idx_reg <= xfer_idx_reg + 5'h01;
          if (xfer_idx_reg == WIN_LAST_IDX) begin
            xfer_reg <= XFER_IDLE;
          end
        end
        default: begin
          xfer_reg <= XFER_IDLE;
        end
      endcase
    end
  end

  // Flash strobes are combinational handshakes; data comes from flops
  assign flash_rd_o       = (xfer_reg == XFER_LOAD);
  assign flash_wr_o       = (xfer_reg == XFER_STORE);
  assign flash_subclass_o = subclass_reg;
  assign flash_block_o    = block_reg;
  assign flash_idx_o      = xfer_idx_reg;
  assign flash_wdata_o    = win_reg[xfer_idx_reg];

  // ----------------------------------------------------------------
  // Block window
  // ----------------------------------------------------------------
  // A wrong checksum starts nothing, so the window stays for a retry
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < WIN_BYTES; i++) begin
        win_reg[i] <= BYTE_RESET;
      end
      info_sel_reg <= 1'b0;
    end else begin
      if (xfer_reg == XFER_LOAD) begin
        win_reg[xfer_idx_reg] <= flash_rdata_i;
      end else if (wr_block && !general_mode) begin
        // Designated-block scheme: only codes 1 and 2 map the info block
        if ((cmd_wdata_i == INFO_BLOCK_A) ||
            (cmd_wdata_i == INFO_BLOCK_B)) begin
          for (int i = 0; i < WIN_BYTES; i++) begin
            win_reg[i] <= info_reg[i];
          end
          info_sel_reg <= 1'b1;
        end else begin
          info_sel_reg <= 1'b0;  // Reserved codes map nothing
        end
      end else if (wr_win) begin
        win_reg[win_idx] <= cmd_wdata_i;
      end
      if (wr_block && general_mode) begin
        info_sel_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Manufacturer info block storage
  // ----------------------------------------------------------------
  // Stands in for the nonvolatile cells; a sealed part never writes it
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < WIN_BYTES; i++) begin
        info_reg[i] <= INFO_RESET;
      end
    end else if (wr_sum && sum_ok && !sealed && !general_mode &&
                 info_sel_reg) begin
      for (int i = 0; i < WIN_BYTES; i++) begin
        info_reg[i] <= win_reg[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Command space readback
  // ----------------------------------------------------------------
  // Subclass and mode read as zero while sealed (user flash hidden)
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmd_rdata_o <= BYTE_RESET;
    end else if (cmd_rd_i) begin
      if ((cmd_addr_i >= ADDR_WIN_BASE) &&
          (cmd_addr_i <= ADDR_WIN_LAST)) begin
        cmd_rdata_o <= win_reg[win_idx];
      end else if (cmd_addr_i == ADDR_BLOCK) begin
        cmd_rdata_o <= block_reg;
      end else if (cmd_addr_i == ADDR_CHECKSUM) begin
        cmd_rdata_o <= checksum_reg;
      end else if (cmd_addr_i == ADDR_SUBCLASS && !sealed) begin
        cmd_rdata_o <= subclass_reg;
      end else if (cmd_addr_i == ADDR_MODE && !sealed) begin
        cmd_rdata_o <= mode_reg;
      end else begin
        cmd_rdata_o <= BYTE_RESET;
      end
    end
  end

  // ----------------------------------------------------------------
  // Security level and key sequence
  // ----------------------------------------------------------------
  // Keys arrive byte-swapped relative to how they read back
  always_comb begin
    if (sealed) begin
      key1_swapped = {unseal_key1_reg[7:0], unseal_key1_reg[15:8]};
      key0_swapped = {unseal_key0_reg[7:0], unseal_key0_reg[15:8]};
    end else begin
      key1_swapped = {full_key1_reg[7:0], full_key1_reg[15:8]};
      key0_swapped = {full_key0_reg[7:0], full_key0_reg[15:8]};
    end
  end

  // Pair must be key 1 then key 0 with nothing else written between.
  // A key 0 equal to a subcommand code would be taken as a key here; a key 1 would not.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      level_reg     <= SEC_SEALED;
      key1_seen_reg <= 1'b0;
    end else if (ctrl_wr_i) begin
      key1_seen_reg <= 1'b0;
      if (key1_seen_reg && (ctrl_wdata_i == key0_swapped)) begin
        if (sealed) begin
          level_reg <= SEC_UNSEALED;
        end else begin
          level_reg <= SEC_FULL;
        end
      end else if (ctrl_wdata_i == CMD_SEAL) begin
        level_reg <= SEC_SEALED;
      end else if ((level_reg != SEC_FULL) &&
                   (ctrl_wdata_i == key1_swapped)) begin
        key1_seen_reg <= 1'b1;
      end
    end
  end

  assign sealed_flag_o            = sealed;
  assign full_access_state_flag_o = (level_reg != SEC_FULL);

  // ----------------------------------------------------------------
  // Stored keys
  // ----------------------------------------------------------------
  // Updates outside full access are dropped silently
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      unseal_key0_reg <= UNSEAL_KEY0_RST;
      unseal_key1_reg <= UNSEAL_KEY1_RST;
      full_key0_reg   <= FULL_KEY0_RST;
      full_key1_reg   <= FULL_KEY1_RST;
    end else if (key_wr_i && (level_reg == SEC_FULL)) begin
      case (key_sel_i)
        KEY_UNSEAL0: unseal_key0_reg <= key_wdata_i;
        KEY_UNSEAL1: unseal_key1_reg <= key_wdata_i;
        KEY_FULL0:   full_key0_reg   <= key_wdata_i;
        KEY_FULL1:   full_key1_reg   <= key_wdata_i;
        default:     unseal_key0_reg <= unseal_key0_reg;
      endcase
    end
  end

  // Key readback, hidden while sealed
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      key_rdata_o <= 16'h0000;
    end else if (key_rd_i) begin
      if (sealed) begin
        key_rdata_o <= 16'h0000;
      end else begin
        case (key_sel_i)
          KEY_UNSEAL0: key_rdata_o <= unseal_key0_reg;
          KEY_UNSEAL1: key_rdata_o <= unseal_key1_reg;
          KEY_FULL0:   key_rdata_o <= full_key0_reg;
          KEY_FULL1:   key_rdata_o <= full_key1_reg;
          default:     key_rdata_o <= 16'h0000;
        endcase
      end
    end
  end

endmodule : secure_flash_block_access

// File: test/secure_flash_block_access_monitor.sv
`timescale 1ns/1ps

// ------------------------------------------------
// Port checker for the block access logic
// ------------------------------------------------
module secure_flash_block_access_monitor
  import nv_access_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        arst_n_i,
  input wire logic        cmd_wr_i,
  input wire logic [6:0]  cmd_addr_i,
  input wire logic        ctrl_wr_i,
  input wire logic [15:0] ctrl_wdata_i,
  input wire logic        key_rd_i,
  input wire logic [15:0] key_rdata_o,
  input wire logic        busy_o,
  input wire logic        sealed_flag_o,
  input wire logic        full_access_state_flag_o,
  input wire logic        flash_rd_o,
  input wire logic        flash_wr_o,
  input wire logic [4:0]  flash_idx_o
);
  logic [5:0] rd_run_reg; // Length of the running load burst

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  // Counter keeps the burst length check cheap for the tools
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_run_reg <= 6'h00;
    end else begin
      rd_run_reg <= flash_rd_o ? rd_run_reg + 6'h01 : 6'h00;
    end
  end

  strobe_busy_a: assert property (
    (flash_rd_o || flash_wr_o) |-> busy_o) else $error("strobe idle");
  strobe_excl_a: assert property (
    !(flash_rd_o && flash_wr_o)) else $error("read and program");
  load_cause_a: assert property (
    $rose(flash_rd_o) |-> flash_idx_o == 5'h00 &&
    $past(cmd_wr_i && cmd_addr_i == ADDR_BLOCK && !sealed_flag_o))
    else $error("load without block write");
  load_step_a: assert property (
    flash_rd_o && $past(flash_rd_o) |->
    flash_idx_o == $past(flash_idx_o) + 5'h01) else $error("load index");
  load_len_a: assert property (
    $fell(flash_rd_o) |-> rd_run_reg == 6'd32) else $error("load length");
  store_cause_a: assert property (
    $rose(flash_wr_o) |->
    $past(cmd_wr_i && cmd_addr_i == ADDR_CHECKSUM && !sealed_flag_o))
    else $error("store without checksum");
  store_len_a: assert property (
    $rose(flash_wr_o) |-> ##31 (flash_wr_o && flash_idx_o == WIN_LAST_IDX)
    ##1 !flash_wr_o) else $error("store length");
  level_order_a: assert property (
    !full_access_state_flag_o |-> !sealed_flag_o) else $error("levels");
  seal_cmd_a: assert property (
    ctrl_wr_i && ctrl_wdata_i == CMD_SEAL |-> ##[1:2] sealed_flag_o)
    else $error("seal not taken");
  unseal_time_a: assert property (
    $fell(sealed_flag_o) |-> $past(ctrl_wr_i) || $past(ctrl_wr_i, 2))
    else $error("unseal without key");
  full_time_a: assert property (
    $fell(full_access_state_flag_o) |->
    $past(ctrl_wr_i) || $past(ctrl_wr_i, 2)) else $error("full no key");
  key_hide_a: assert property (
    key_rd_i && sealed_flag_o |=> key_rdata_o == 16'h0000)
    else $error("key shown while sealed");

  cover property ($rose(flash_rd_o));
  cover property ($rose(flash_wr_o));
  cover property ($fell(full_access_state_flag_o));
endmodule : secure_flash_block_access_monitor

bind secure_flash_block_access secure_flash_block_access_monitor i_mon (
  .sys_clk_i, .arst_n_i, .cmd_wr_i, .cmd_addr_i, .ctrl_wr_i,
  .ctrl_wdata_i, .key_rd_i, .key_rdata_o, .busy_o, .sealed_flag_o,
  .full_access_state_flag_o, .flash_rd_o, .flash_wr_o, .flash_idx_o);

// File: test/flash_store_model.sv
`timescale 1ns/1ps

// ------------------------------------------------
// Behavioural parameter flash behind the block
// ------------------------------------------------
module flash_store_model (
  input  wire logic       sys_clk_i,
  input  wire logic       flash_rd_i,  // Read strobe
  input  wire logic       flash_wr_i,  // Program strobe
  input  wire logic [7:0] subclass_i,  // Subclass of transfer
  input  wire logic [7:0] block_i,     // 32-byte block number
  input  wire logic [4:0] idx_i,       // Byte within block
  input  wire logic [7:0] wdata_i,     // Byte to program
  output logic      [7:0] rdata_o      // Byte read
);
  logic [7:0] mem [0:511]; // Known pattern, address xor 0x5a
  logic [7:0] last_reg;    // Last byte driven
  logic [8:0] addr;        // Subclass and block pick the 32 bytes

  assign addr = {subclass_i[1:0], block_i[1:0], idx_i};

  // Preload a pattern so every byte of a block differs
  initial begin
    for (int i = 0; i < 512; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
  end

  // Program and read one byte a cycle
  always @(posedge sys_clk_i) begin
    if (flash_wr_i) begin
      mem[addr] <= wdata_i;
    end
    if (flash_rd_i) begin
      last_reg <= mem[addr];
    end
  end

  // Outside a read the line shows junk, never the last byte
  assign rdata_o = flash_rd_i ? mem[addr] : ~last_reg;
endmodule : flash_store_model

// File: test/secure_flash_block_access_bench.sv
`timescale 1ns/1ps

module secure_flash_block_access_bench
  import nv_access_pkg::*;
;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic        sys_clk_i;
  logic        arst_n_i     = 1'b0;
  logic        cmd_wr_i     = 1'b0;
  logic        cmd_rd_i     = 1'b0;
  logic [6:0]  cmd_addr_i   = 7'h00;
  logic [7:0]  cmd_wdata_i  = 8'h00;
  logic        ctrl_wr_i    = 1'b0;
  logic [15:0] ctrl_wdata_i = 16'h0000;
  logic        key_wr_i     = 1'b0;
  logic        key_rd_i     = 1'b0;
  logic [1:0]  key_sel_i    = 2'h0;
  logic [15:0] key_wdata_i  = 16'h0000;
  logic [7:0]  cmd_rdata_o, flash_subclass_o, flash_block_o;
  logic [7:0]  flash_wdata_o, flash_rdata_i;
  logic [15:0] key_rdata_o;
  logic [4:0]  flash_idx_o;
  logic        busy_o, sealed_flag_o, full_access_state_flag_o;
  logic        flash_rd_o, flash_wr_o;
  int          num_errors   = 0;
  int          checks       = 0;

  secure_flash_block_access i_dut (
    .sys_clk_i, .arst_n_i, .cmd_wr_i, .cmd_rd_i, .cmd_addr_i,
    .cmd_wdata_i, .cmd_rdata_o, .busy_o, .ctrl_wr_i, .ctrl_wdata_i,
    .sealed_flag_o, .full_access_state_flag_o, .key_wr_i, .key_rd_i,
    .key_sel_i, .key_wdata_i, .key_rdata_o, .flash_rd_o, .flash_wr_o,
    .flash_subclass_o, .flash_block_o, .flash_idx_o, .flash_wdata_o,
    .flash_rdata_i);

  flash_store_model i_flash (
    .sys_clk_i, .flash_rd_i(flash_rd_o), .flash_wr_i(flash_wr_o),
    .subclass_i(flash_subclass_o), .block_i(flash_block_o),
    .idx_i(flash_idx_o), .wdata_i(flash_wdata_o), .rdata_o(flash_rdata_i));

  // ----------------------------------------
  // Port tasks
  // ----------------------------------------
  task automatic chk(input string w, input logic [15:0] e,
                     input logic [15:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", w, e, g);
    end
  endtask : chk

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    cmd_wr_i    <= 1'b1;
    cmd_addr_i  <= a;
    cmd_wdata_i <= d;
    @(posedge sys_clk_i);
    cmd_wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    cmd_rd_i   <= 1'b1;
    cmd_addr_i <= a;
    @(posedge sys_clk_i);
    cmd_rd_i   <= 1'b0;
    #1 d = cmd_rdata_o;
  endtask : rd

  // Write, then count the busy cycles it launches (bounded)
  task automatic xfer(input logic [6:0] a, input logic [7:0] d,
                      input int n, input string w);
    int cnt;
    cnt = 0;
    wr(a, d);
    #1;
    while (busy_o === 1'b1 && cnt < 40) begin
      cnt++;
      @(posedge sys_clk_i);
      #1;
    end
    chk(w, 16'(n), 16'(cnt));
  endtask : xfer

  task automatic ctrl(input logic [15:0] w);
    @(posedge sys_clk_i);
    ctrl_wr_i    <= 1'b1;
    ctrl_wdata_i <= w;
    @(posedge sys_clk_i);
    ctrl_wr_i    <= 1'b0;
  endtask : ctrl

  task automatic keyw(input logic [1:0] s, input logic [15:0] d);
    @(posedge sys_clk_i);
    key_wr_i    <= 1'b1;
    key_sel_i   <= s;
    key_wdata_i <= d;
    @(posedge sys_clk_i);
    key_wr_i    <= 1'b0;
  endtask : keyw

  task automatic keyr(input logic [1:0] s, output logic [15:0] q);
    @(posedge sys_clk_i);
    key_rd_i  <= 1'b1;
    key_sel_i <= s;
    @(posedge sys_clk_i);
    key_rd_i  <= 1'b0;
    #1 q = key_rdata_o;
  endtask : keyr

  // Flags are judged one cycle after the last key edge
  task automatic flags(input logic s, input logic f);
    @(posedge sys_clk_i);
    #1;
    chk("sealed flag", 16'(s), 16'(sealed_flag_o));
    chk("full flag", 16'(f), 16'(full_access_state_flag_o));
  endtask : flags

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_sealed();
    logic [7:0]  d;
    logic [15:0] k;
    flags(1'b1, 1'b1);
    keyr(KEY_UNSEAL1, k);
    chk("sealed key read", 16'h0000, k);
    wr(ADDR_SUBCLASS, 8'h50);
    xfer(ADDR_BLOCK, 8'h00, 0, "sealed flash busy");
    chk("sealed subclass", 16'h0000, flash_subclass_o);
    xfer(ADDR_BLOCK, INFO_BLOCK_A, 0, "sealed info busy");
    wr(ADDR_WIN_BASE, 8'h77);
    rd(ADDR_WIN_BASE, d);
    chk("sealed window", INFO_RESET, d);
    xfer(ADDR_CHECKSUM, 8'hff, 0, "sealed commit busy");
    $display("test sealed done");
  endtask : t_sealed

  // Keys go in byte-swapped, key 1 first; a stray write voids the pair
  task automatic t_unseal();
    ctrl(16'h2b4c);
    ctrl(16'h0001);
    ctrl(16'h179e);
    flags(1'b1, 1'b1);
    ctrl(16'h2b4c);
    ctrl(16'h179e);
    flags(1'b0, 1'b1);
    $display("test unseal done");
  endtask : t_unseal

  task automatic t_load();
    logic [7:0] d;
    logic [7:0] sum;
    sum = 8'h00;
    wr(ADDR_MODE, MODE_GENERAL);
    wr(ADDR_SUBCLASS, 8'h50);
    xfer(ADDR_BLOCK, 8'h01, 32, "load busy");
    chk("subclass", 16'h0050, flash_subclass_o);
    for (int i = 0; i < WIN_BYTES; i++) begin
      rd(ADDR_WIN_BASE + 7'(i), d);
      chk("window byte", 8'(32 + i) ^ 8'h5a, d);
      sum += (i == 21) ? 8'ha5 : 8'(32 + i) ^ 8'h5a;
    end
    wr(ADDR_WIN_BASE + 7'd21, 8'ha5);
    xfer(ADDR_CHECKSUM, ~sum ^ 8'h01, 0, "bad sum busy");
    rd(ADDR_WIN_BASE + 7'd21, d);
    chk("window kept", 8'ha5, d);
    chk("flash kept", 8'h35 ^ 8'h5a, i_flash.mem[53]);
    xfer(ADDR_CHECKSUM, ~sum, 32, "store busy");
    chk("flash stored", 8'ha5, i_flash.mem[53]);
    $display("test load store done");
  endtask : t_load

  task automatic t_info();
    logic [7:0] d;
    wr(ADDR_MODE, 8'h01);
    xfer(ADDR_BLOCK, INFO_BLOCK_B, 0, "info select busy");
    for (int i = 0; i < WIN_BYTES; i++) begin
      wr(ADDR_WIN_BASE + 7'(i), 8'(i + 1));
    end
    xfer(ADDR_CHECKSUM, 8'hef, 0, "info commit busy");
    wr(ADDR_MODE, MODE_GENERAL);
    xfer(ADDR_BLOCK, 8'h00, 32, "reload busy");
    wr(ADDR_MODE, 8'h01);
    xfer(ADDR_BLOCK, INFO_BLOCK_A, 0, "info reselect busy");
    for (int i = 0; i < WIN_BYTES; i++) begin
      rd(ADDR_WIN_BASE + 7'(i), d);
      chk("info byte", 8'(i + 1), d);
    end
    $display("test info done");
  endtask : t_info

  // New key value is kept clear of every control subcommand
  task automatic t_keys();
    logic [7:0]  d;
    logic [15:0] k;
    keyw(KEY_UNSEAL0, 16'h1111);
    keyr(KEY_UNSEAL0, k);
    chk("key locked", UNSEAL_KEY0_RST, k);
    ctrl(16'hffff);
    ctrl(16'hffff);
    flags(1'b0, 1'b0);
    keyw(KEY_UNSEAL0, 16'h1111);
    keyr(KEY_UNSEAL0, k);
    chk("key updated", 16'h1111, k);
    keyr(KEY_FULL1, k);
    chk("full key", FULL_KEY1_RST, k);
    ctrl(CMD_SEAL);
    flags(1'b1, 1'b1);
    xfer(ADDR_BLOCK, INFO_BLOCK_A, 0, "sealed reselect");
    wr(ADDR_WIN_BASE, 8'h77);
    rd(ADDR_WIN_BASE, d);
    chk("info read only", 8'h01, d);
    $display("test keys done");
  endtask : t_keys

  task automatic final_report();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  // 250 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    t_sealed();
    t_unseal();
    t_load();
    t_info();
    t_keys();
    final_report();
  end

  // Tests need about 400 cycles; cut a hang well after that
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    num_errors++;
    $display("ERROR watchdog expected end seen timeout");
    final_report();
  end
endmodule : secure_flash_block_access_bench
